// >>> design/backlight_control_registers.sv
`timescale 1ns/1ps
module backlight_control_registers #(
  parameter logic [7:0] PART_ID  = 8'h5a, // arbitrary value
  parameter logic [3:0] REV_CODE = 4'h6   // arbitrary value
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // two-wire serial bus
  input  wire logic [6:0]  slave_address,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // analog side inputs
  input  wire logic        overcurrent_detect,
  input  wire logic        dim_pin,
  input  wire logic        dim_period_start,
  // decoded controls
  output logic             packet_check_enable,
  output logic             boost_limit_select,
  output logic             force_boost_run,
  output logic             fast_soft_start,
  output logic             converter_outputs_enable,
  output logic             phase_shift_enable,
  output logic             pin_dimming_select,
  output logic             hybrid_dimming_enable,
  output logic [1:0]       hybrid_threshold_select,
  output logic [6:0]       led_current_code,
  output logic [17:0]      sink_current_ua,
  output logic [17:0]      ch1_on_time,
  output logic [17:0]      ch2_on_time,
  // drive and status
  output logic             boost_run,
  output logic [1:0]       led_drive,
  output logic             input_overcurrent_flag,
  output logic             fault_output_n
);
  import bl_regs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
  } bus_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int k = 0; k < 8; k++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [5:0]  setup_q, setup_d;
  logic [4:0]  mode_q, mode_d;
  logic [6:0]  iset_q, iset_d;
  logic [7:0]  ton_hi_q [2], ton_hi_d [2];
  logic [7:0]  ton_md_q [2], ton_md_d [2];
  logic [7:0]  lsb14_q, lsb14_d;
  logic [4:0]  lsb56_q, lsb56_d;
  logic        ocf_q, ocf_d;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    unique case (a)
      ADDR_IDENT:  return PART_ID;
      ADDR_REV:    return {4'h0, REV_CODE};
      ADDR_SETUP:  return {2'h0, setup_q};
      ADDR_MODE:   return {3'h0, mode_q};
      ADDR_ISET:   return {1'h0, iset_q};
      ADDR_CH1_HI: return ton_hi_q[0];
      ADDR_CH1_MD: return ton_md_q[0];
      ADDR_CH2_HI: return ton_hi_q[1];
      ADDR_CH2_MD: return ton_md_q[1];
      ADDR_LSB14:  return lsb14_q;
      ADDR_LSB56:  return {3'h0, lsb56_q};
      default:     return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // serial bus slave
  // ----------------------------------------------------------------
  bus_state_t  st_q, st_d;
  logic        scl_q, sda_q;
  logic [2:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  tx_q, tx_d;
  logic        drv_q, drv_d;
  logic        rw_q, rw_d;
  logic [7:0]  ptr_q, ptr_d;
  logic [7:0]  crc_q, crc_d;
  logic [1:0]  nb_q, nb_d;
  logic        sent_q, sent_d;
  logic [7:0]  pend_q, pend_d;
  logic [7:0]  pptr_q, pptr_d;
  logic        wr_en;
  logic [7:0]  wr_addr, wr_data;
  logic        start_c, stop_c, rise_c, fall_c;
  logic [7:0]  byte_c, nxt_c;

  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c  = scl_in & scl_q & ~sda_q & sda_in;
  assign rise_c  = scl_in & ~scl_q;
  assign fall_c  = ~scl_in & scl_q;
  assign byte_c  = {sh_q[6:0], sda_in};

  // bus next state; one byte in flight, pointer auto-increments except on checked writes
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; tx_d = tx_q;
    drv_d = drv_q; rw_d = rw_q; ptr_d = ptr_q; crc_d = crc_q;
    nb_d = nb_q; sent_d = sent_q; pend_d = pend_q; pptr_d = pptr_q;
    wr_en = 1'b0; wr_addr = ptr_q; wr_data = byte_c;
    nxt_c = packet_check_enable && sent_q ? crc_q : rd_byte(ptr_q);
    if (stop_c) begin
      // checked write lands only when the code matched
      if (packet_check_enable && !rw_q && nb_q == 2'd3 &&
          crc_q == 8'h00) begin
        wr_en = 1'b1; wr_addr = pptr_q; wr_data = pend_q;
      end
      st_d = ST_IDLE; drv_d = 1'b0;
    end else if (start_c) begin
      if (st_q == ST_IDLE) begin
        crc_d = 8'h00; nb_d = 2'd0;
      end
      st_d = ST_ADDR; cnt_d = 3'd0; drv_d = 1'b0; sent_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: ;
        ST_ADDR, ST_WR: if (rise_c) begin
          sh_d = byte_c;
          cnt_d = cnt_q + 3'd1;
          if (cnt_q == 3'd7) begin
            crc_d = crc8(crc_q, byte_c);
            if (st_q == ST_ADDR) begin
              rw_d = byte_c[0];
              st_d = byte_c[7:1] == slave_address ? ST_ACK_ADDR : ST_IDLE;
            end else begin
              st_d = ST_ACK_WR;
              if (nb_q != 2'd3) nb_d = nb_q + 2'd1;
              if (nb_q == 2'd0) ptr_d = byte_c;
              else if (!packet_check_enable) begin
                wr_en = 1'b1; ptr_d = ptr_q + 8'd1;
              end else if (nb_q == 2'd1) begin
                pend_d = byte_c; pptr_d = ptr_q; // held for
              end
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR: if (fall_c) begin
          if (!drv_q) drv_d = 1'b1;
          else if (st_q == ST_ACK_ADDR && rw_q) begin
            tx_d = nxt_c; drv_d = ~nxt_c[7]; cnt_d = 3'd0; st_d = ST_RD;
            if (!(packet_check_enable && sent_q)) crc_d = crc8(crc_q, nxt_c);
            sent_d = 1'b1;
          end else begin
            drv_d = 1'b0; cnt_d = 3'd0; st_d = ST_WR;
          end
        end
        ST_RD: begin
          if (fall_c && cnt_q != 3'd0) begin
            tx_d = tx_q << 1; drv_d = ~tx_q[6];
          end else if (fall_c) drv_d = ~tx_q[7];
          if (rise_c) begin
            cnt_d = cnt_q + 3'd1;
            if (cnt_q == 3'd7) st_d = ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          if (fall_c) drv_d = 1'b0;
          if (rise_c && !drv_q) begin
            if (sda_in) st_d = ST_IDLE;
            else begin
              ptr_d = ptr_q + 8'd1;
              tx_d = packet_check_enable ? crc_q : rd_byte(ptr_q + 8'd1);
              if (!packet_check_enable)
                crc_d = crc8(crc_q, rd_byte(ptr_q + 8'd1));
              cnt_d = 3'd0; st_d = ST_RD;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; cnt_q <= 3'd0;
      sh_q <= 8'h00; tx_q <= 8'h00; drv_q <= 1'b0; rw_q <= 1'b0;
      ptr_q <= 8'h00; crc_q <= 8'h00; nb_q <= 2'd0; sent_q <= 1'b0;
      pend_q <= 8'h00; pptr_q <= 8'h00;
    end else if (clk_en) begin
      st_q <= st_d; scl_q <= scl_in; sda_q <= sda_in; cnt_q <= cnt_d;
      sh_q <= sh_d; tx_q <= tx_d; drv_q <= drv_d; rw_q <= rw_d;
      ptr_q <= ptr_d; crc_q <= crc_d; nb_q <= nb_d; sent_q <= sent_d;
      pend_q <= pend_d; pptr_q <= pptr_d;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe  = drv_q;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // identity and revision have no write path at all
  always_comb begin
    setup_d = setup_q; mode_d = mode_q; iset_d = iset_q;
    ton_hi_d = ton_hi_q; ton_md_d = ton_md_q;
    lsb14_d = lsb14_q; lsb56_d = lsb56_q;
    ocf_d = ocf_q | overcurrent_detect; // sticky until reset
    if (wr_en) begin
      unique case (wr_addr)
        ADDR_SETUP:  setup_d = wr_data[5:0];
        ADDR_MODE:   mode_d = wr_data[4:0];
        ADDR_ISET:   iset_d = wr_data[6:0];
        ADDR_CH1_HI: ton_hi_d[0] = wr_data;
        ADDR_CH1_MD: ton_md_d[0] = wr_data;
        ADDR_CH2_HI: ton_hi_d[1] = wr_data;
        ADDR_CH2_MD: ton_md_d[1] = wr_data;
        ADDR_LSB14:  lsb14_d = wr_data;
        ADDR_LSB56:  lsb56_d = wr_data[4:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      setup_q <= SETUP_RST; mode_q <= MODE_RST; iset_q <= ISET_RST;
      ton_hi_q[0] <= TON_RST; ton_hi_q[1] <= TON_RST;
      ton_md_q[0] <= TON_RST; ton_md_q[1] <= TON_RST;
      lsb14_q <= LSB14_RST; lsb56_q <= LSB56_RST; ocf_q <= 1'b0;
    end else if (clk_en) begin
      setup_q <= setup_d; mode_q <= mode_d; iset_q <= iset_d;
      ton_hi_q <= ton_hi_d; ton_md_q <= ton_md_d;
      lsb14_q <= lsb14_d; lsb56_q <= lsb56_d; ocf_q <= ocf_d;
    end
  end

  // field decode
  assign packet_check_enable      = setup_q[SET_PEC_BIT];
  assign boost_limit_select       = setup_q[SET_ILIM_BIT];
  assign force_boost_run          = setup_q[SET_FORCE_BIT];
  assign fast_soft_start          = setup_q[SET_FSS_BIT];
  assign converter_outputs_enable = setup_q[SET_ENA_BIT];
  assign phase_shift_enable       = setup_q[SET_PS_BIT];
  assign pin_dimming_select       = mode_q[MODE_PIN_BIT];
  assign hybrid_dimming_enable    = mode_q[MODE_HYB_BIT];
  assign hybrid_threshold_select  = mode_q[MODE_THR_LSB +: 2];
  assign led_current_code         = iset_q;
  assign sink_current_ua = CURRENT_BASE_UA +
    18'(CURRENT_STEP_UA * {11'h000, iset_q});
  assign input_overcurrent_flag   = ocf_q;

  // ----------------------------------------------------------------
  // overcurrent, enable and dimming
  // ----------------------------------------------------------------
  logic shut_c, run_c;
  logic [17:0] ton_own [2];
  logic [17:0] ton_eff [2];
  logic [1:0]  pwm_on, dim_c;

  // shutdown only when the disable bit is clear
  assign shut_c = ocf_q & ~mode_q[MODE_OCD_BIT];
  assign fault_output_n = ~shut_c;
  assign run_c = setup_q[SET_ENA_BIT] & ~shut_c;
  assign ton_own[0] = {ton_hi_q[0], ton_md_q[0],
                       lsb14_q[LSB_CH1_POS +: 2]};
  assign ton_own[1] = {ton_hi_q[1], ton_md_q[1],
                       lsb14_q[LSB_CH2_POS +: 2]};
  assign ch1_on_time = ton_eff[0];
  assign ch2_on_time = ton_eff[1];

  // per-channel on-time counters, one prescaled 50ns tick each
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [17:0] rem_q, rem_d;
    logic [2:0]  pre_q, pre_d;
    assign ton_eff[i] = lsb56_q[COMMON_BIT] ? ton_own[0]
                                            : ton_own[i];
    always_comb begin
      rem_d = rem_q;
      pre_d = pre_q;
      if (dim_period_start) begin
        rem_d = ton_eff[i];
        pre_d = 3'd0;
      end else if (rem_q != 18'd0) begin
        if (pre_q == 3'(ON_TIME_UNIT_CYC - 1)) begin
          pre_d = 3'd0;
          rem_d = rem_q - 18'd1;
        end else pre_d = pre_q + 3'd1;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        rem_q <= 18'd0;
        pre_q <= 3'd0;
      end else if (clk_en) begin
        rem_q <= rem_d;
        pre_q <= pre_d;
      end
    end
    assign pwm_on[i] = rem_q != 18'd0;
    assign dim_c[i] = pin_dimming_select ? dim_pin : pwm_on[i];
  end

  // forced boost ignores the dimming level entirely
  assign boost_run = run_c & (setup_q[SET_FORCE_BIT] | (|dim_c));
  assign led_drive = {2{run_c}} & dim_c;

endmodule

// >>> design/bl_regs_pkg.sv
// What this block does
// - packet-check bit 5 adds a checked CRC byte to every transfer
// - setup bit 4 picks high current limit at 0, low at 1
// - setup bit 3 runs the boost continuously, ignoring dimming
// - setup bit 2 picks fast soft-start at 1, slow at 0
// - setup bit 1 enables boost and LED outputs, 0 keeps them off
// - setup bit 0 turns phase shifting between channels on at 1
// - mode bit 4 set: overcurrent only flags, no shutdown, fault high
// - mode bit 3 picks pin dimming at 1, on-time registers at 0
// - mode bit 2 enables hybrid dimming; 2-bit threshold code 6.25-50%
// - 7-bit current code, 34.5mA at 0x00 to 225mA at 0x7f
// - each channel has 18-bit on-time, top eight in its high byte
// - on-time counts in 50ns units
// - middle on-time byte is read-write and resets to all ones
// - two low on-time bits per channel sit in a shared register
// - common bit set: channel 1 on-time drives every active channel
package bl_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IDENT  = 8'h00;
  localparam logic [7:0] ADDR_REV    = 8'h01;
  localparam logic [7:0] ADDR_SETUP  = 8'h02;
  localparam logic [7:0] ADDR_MODE   = 8'h03;
  localparam logic [7:0] ADDR_ISET   = 8'h04;
  localparam logic [7:0] ADDR_CH1_HI = 8'h05;
  localparam logic [7:0] ADDR_CH1_MD = 8'h06;
  localparam logic [7:0] ADDR_CH2_HI = 8'h07;
  localparam logic [7:0] ADDR_CH2_MD = 8'h08;
  localparam logic [7:0] ADDR_LSB14  = 8'h0d;
  localparam logic [7:0] ADDR_LSB56  = 8'h12;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SET_PEC_BIT   = 5;
  localparam int SET_ILIM_BIT  = 4;
  localparam int SET_FORCE_BIT = 3;
  localparam int SET_FSS_BIT   = 2;
  localparam int SET_ENA_BIT   = 1;
  localparam int SET_PS_BIT    = 0;
  localparam int MODE_OCD_BIT  = 4;
  localparam int MODE_PIN_BIT  = 3;
  localparam int MODE_HYB_BIT  = 2;
  localparam int MODE_THR_LSB  = 0;
  localparam int LSB_CH1_POS   = 0;
  localparam int LSB_CH2_POS   = 2;
  localparam int COMMON_BIT    = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] SETUP_RST = 6'h00;
  localparam logic [4:0] MODE_RST  = 5'h08;
  localparam logic [6:0] ISET_RST  = 7'h08;
  localparam logic [7:0] TON_RST   = 8'hff;
  localparam logic [7:0] LSB14_RST = 8'hff;
  localparam logic [4:0] LSB56_RST = 5'h0f;

  // ----------------------------------------------------------------
  // timing and scaling
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int ON_TIME_UNIT_NS = 50;
  localparam int ON_TIME_UNIT_CYC =
    (ON_TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [17:0] CURRENT_BASE_UA = 18'd34500;
  localparam logic [17:0] CURRENT_STEP_UA = 18'd1500;
  localparam logic [7:0]  CRC_POLY        = 8'h07;

endpackage

// >>> bench/bl_regs_props.sv
`timescale 1ns/1ps
module bl_regs_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // decoded controls
  input wire logic        packet_check_enable,
  input wire logic        boost_limit_select,
  input wire logic        force_boost_run,
  input wire logic        fast_soft_start,
  input wire logic        converter_outputs_enable,
  input wire logic        phase_shift_enable,
  input wire logic        pin_dimming_select,
  input wire logic        hybrid_dimming_enable,
  input wire logic [1:0]  hybrid_threshold_select,
  input wire logic [6:0]  led_current_code,
  input wire logic [17:0] sink_current_ua,
  // drive and status
  input wire logic        dim_pin,
  input wire logic        boost_run,
  input wire logic [1:0]  led_drive,
  input wire logic        input_overcurrent_flag,
  input wire logic        fault_output_n
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_SETUP_RST:
    assert property ($fell(sys_rst) |-> {packet_check_enable,
      boost_limit_select, force_boost_run, fast_soft_start,
      converter_outputs_enable, phase_shift_enable} == 6'h00)
      else $error("setup bits not cleared by reset");
  AST_MODE_RST:
    assert property ($fell(sys_rst) |-> pin_dimming_select &&
      !hybrid_dimming_enable && hybrid_threshold_select == 2'h0)
      else $error("mode bits not at reset value");
  AST_CURRENT_MAP:
    assert property (sink_current_ua ==
      18'd34500 + 18'd1500 * {11'h000, led_current_code})
      else $error("sink current does not match code");
  AST_OFF_QUIET:
    assert property (!converter_outputs_enable |-> !boost_run &&
      led_drive == 2'h0) else $error("outputs active while disabled");
  AST_FORCE_RUN:
    assert property (converter_outputs_enable && force_boost_run &&
      !input_overcurrent_flag |-> boost_run) else $error("boost idle");
  AST_FLAG_HOLD:
    assert property (input_overcurrent_flag |=> input_overcurrent_flag)
      else $error("overcurrent flag dropped");
  AST_FAULT_IDLE:
    assert property (!input_overcurrent_flag |-> fault_output_n)
      else $error("fault low without overcurrent");
  AST_FAULT_STOP:
    assert property (!fault_output_n |-> !boost_run && led_drive == 2'h0)
      else $error("drive active during shutdown");
  AST_PIN_DIM:
    assert property ((converter_outputs_enable && pin_dimming_select &&
      !hybrid_dimming_enable && !input_overcurrent_flag && dim_pin)[*3]
      |-> led_drive == 2'h3) else $error("pin dimming not followed");
endmodule
bind backlight_control_registers bl_regs_props chk_u (
  .ref_clk, .sys_rst, .packet_check_enable, .boost_limit_select,
  .force_boost_run, .fast_soft_start, .converter_outputs_enable,
  .phase_shift_enable, .pin_dimming_select, .hybrid_dimming_enable,
  .hybrid_threshold_select, .led_current_code, .sink_current_ua,
  .dim_pin, .boost_run, .led_drive, .input_overcurrent_flag,
  .fault_output_n
);

// >>> bench/bl_host_model.sv
`timescale 1ns/1ps
module bl_host_model #(
  parameter logic [6:0] ADR = 7'h2c
) (
  // clock
  input  wire logic ref_clk,
  // two-wire bus
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda_w
);
  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic [7:0] crc = 8'h00;
  int         nak = 0;
  // pull-up: wire high unless a party pulls it low
  assign sda_w = sda_q & ~sda_oe;
  assign scl   = scl_q;
  // crc-8, poly 0x07, zero start
  function automatic logic [7:0] f(logic [7:0] c, logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++)
      x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction
  // pin changes land on a clock edge, then wait n edges
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic sd(input logic v, input int n);
    sda_q <= v;
    tk(n);
  endtask
  task automatic sc(input logic v, input int n);
    scl_q <= v;
    tk(n);
  endtask
  // sda only moves while scl is low; scl held 4 cycles each way
  task automatic bt(input logic b, output logic r);
    tk(1);
    sd(b, 3);
    sc(1'b1, 2);
    r = sda_w;
    tk(2);
    sc(1'b0, 0);
  endtask
  task automatic strt(input logic first);
    tk(1);
    sd(1'b1, 2);
    sc(1'b1, 3);
    sd(1'b0, 3);
    sc(1'b0, 0);
    if (first) crc = 8'h00;
  endtask
  task automatic stop;
    tk(1);
    sd(1'b0, 2);
    sc(1'b1, 3);
    sd(1'b1, 4);
  endtask
  task automatic sb(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bt(b[i], r);
    bt(1'b1, r);
    if (r) nak++;
    crc = f(crc, b);
  endtask
  task automatic rb(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(last, r);
    crc = f(crc, d);
  endtask
  // pointer then data; optional check byte, bad flips its lsb
  task automatic wr(input logic [7:0] q[4], input int n,
                    input logic pec, input logic bad);
    strt(1'b1);
    sb({ADR, 1'b0});
    for (int i = 0; i < n; i++) sb(q[i]);
    if (pec) sb(crc ^ {7'h00, bad});
    stop;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    strt(1'b1);
    sb({ADR, 1'b0});
    sb(p);
    strt(1'b0);
    sb({ADR, 1'b1});
    rb(d, 1'b1);
    stop;
  endtask
endmodule

// >>> bench/tb_backlight_control_registers.sv
`timescale 1ns/1ps
module tb_backlight_control_registers;
  import bl_regs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [6:0] ADR = 7'h2c;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [6:0]  slave_address = ADR;
  logic        overcurrent_detect = 1'b0;
  logic        dim_pin = 1'b0;
  logic        dim_period_start = 1'b0;
  logic        scl, sda_w, sda_out, sda_oe, packet_check_enable;
  logic        boost_limit_select, force_boost_run, fast_soft_start;
  logic        converter_outputs_enable, phase_shift_enable, boost_run;
  logic        pin_dimming_select, hybrid_dimming_enable;
  logic        input_overcurrent_flag, fault_output_n;
  logic [1:0]  hybrid_threshold_select, led_drive;
  logic [6:0]  led_current_code;
  logic [17:0] sink_current_ua, ch1_on_time, ch2_on_time;
  logic [5:0]  su;
  logic [4:0]  st;
  logic [3:0]  md;
  logic [7:0]  d;
  int          err_total = 0;
  int          checks = 0;
  int          on_cnt = 0;
  // reset image of 0x00..0x09; identity values arbitrary
  logic [7:0]  rv [10] = '{8'h3c, 8'h09, 8'h00, 8'h08, 8'h08,
                           8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  // grouped views of the outputs
  assign su = {packet_check_enable, boost_limit_select, force_boost_run,
               fast_soft_start, converter_outputs_enable,
               phase_shift_enable};
  assign st = {boost_run, led_drive, input_overcurrent_flag,
               fault_output_n};
  assign md = {pin_dimming_select, hybrid_dimming_enable,
               hybrid_threshold_select};
  always #5 ref_clk = ~ref_clk;
  backlight_control_registers #(.PART_ID(8'h3c), .REV_CODE(4'h9)) dut_u (
    .ref_clk, .sys_rst, .clk_en, .slave_address, .scl_in(scl),
    .sda_in(sda_w), .sda_out, .sda_oe, .overcurrent_detect, .dim_pin,
    .dim_period_start, .packet_check_enable, .boost_limit_select,
    .force_boost_run, .fast_soft_start, .converter_outputs_enable,
    .phase_shift_enable, .pin_dimming_select, .hybrid_dimming_enable,
    .hybrid_threshold_select, .led_current_code, .sink_current_ua,
    .ch1_on_time, .ch2_on_time, .boost_run, .led_drive,
    .input_overcurrent_flag, .fault_output_n
  );
  bl_host_model #(.ADR(ADR)) host_u (.ref_clk, .sda_oe, .scl, .sda_w);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [17:0] s, input logic [17:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic w2(input logic [7:0] a, input logic [7:0] v);
    host_u.wr('{a, v, 8'h00, 8'h00}, 2, 1'b0, 1'b0);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(18'(d), 18'(e));
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: tests need about 120 us, so allow well over twice that
  initial begin
    #400_000;
    err_total++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) rchk(8'(i), rv[i]);
    chk(sink_current_ua, 18'd46500);
    chk(18'(sda_out), 18'h0);
    chk(ch1_on_time, 18'h3ffff);
    chk(ch2_on_time, 18'h3ffff);
    $display("test reset done");
    host_u.wr('{8'h00, 8'h11, 8'h22, 8'h00}, 3, 1'b0, 1'b0);
    rchk(8'h00, 8'h3c);
    rchk(8'h01, 8'h09);
    host_u.wr('{8'h05, 8'h12, 8'h34, 8'h56}, 4, 1'b0, 1'b0);
    w2(8'h08, 8'h78);
    chk(ch1_on_time, {8'h12, 8'h34, 2'h3});
    chk(ch2_on_time, {8'h56, 8'h78, 2'h3});
    rchk(8'h06, 8'h34);
    w2(8'h0d, 8'h00);
    chk(ch1_on_time, {8'h12, 8'h34, 2'h0});
    w2(8'h12, 8'h10);
    chk(ch2_on_time, {8'h12, 8'h34, 2'h0});
    $display("test on-time done");
    w2(8'h02, 8'h0b);
    chk(18'(su), 18'h0b);
    chk(18'(st), 18'h11);
    w2(8'h02, 8'h16);
    chk(18'(su), 18'h16);
    chk(18'(st), 18'h01);
    for (int c = 0; c < 4; c++) begin
      w2(8'h03, 8'(4 + c));
      chk(18'(md), 18'(4 + c));
    end
    w2(8'h04, 8'h7f);
    chk(sink_current_ua, 18'd225000);
    w2(8'h04, 8'h2c);
    chk(sink_current_ua, 18'd100500);
    chk(18'(led_current_code), 18'h2c);
    $display("test controls done");
    w2(8'h03, 8'h08);
    w2(8'h02, 8'h02);
    dim_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(18'(st), 18'h1d);
    w2(8'h02, 8'h00);
    chk(18'(st), 18'h01);
    $display("test dimming done");
    // on-time of 3 units, shared by both channels through the common bit;
    // first pass holds the clock enable low so the load must not happen
    w2(8'h03, 8'h00);
    w2(8'h02, 8'h02);
    host_u.wr('{8'h05, 8'h00, 8'h00, 8'h00}, 3, 1'b0, 1'b0);
    w2(8'h0d, 8'h03);
    for (int p = 0; p < 2; p++) begin
      on_cnt = 0;
      clk_en <= p[0];
      dim_period_start <= 1'b1;
      @(posedge ref_clk);
      dim_period_start <= 1'b0;
      clk_en <= 1'b1;
      repeat (30) begin
        @(posedge ref_clk);
        if (led_drive == 2'h3) on_cnt++;
      end
      // 3 units of 50ns at a 10ns clock
      chk(18'(on_cnt), 18'(p * 15));
    end
    $display("test pwm done");
    w2(8'h02, 8'h02);
    w2(8'h03, 8'h18);
    overcurrent_detect <= 1'b1;
    @(posedge ref_clk);
    overcurrent_detect <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(18'(st), 18'h1f);
    w2(8'h03, 8'h08);
    chk(18'(st), 18'h02);
    $display("test overcurrent done");
    w2(8'h02, 8'h20);
    chk(18'(su), 18'h20);
    host_u.wr('{8'h04, 8'h11, 8'h00, 8'h00}, 2, 1'b1, 1'b0);
    rchk(8'h04, 8'h11);
    host_u.wr('{8'h04, 8'h22, 8'h00, 8'h00}, 2, 1'b1, 1'b1);
    rchk(8'h04, 8'h11);
    w2(8'h04, 8'h33);
    rchk(8'h04, 8'h11);
    chk(18'(host_u.nak), 18'h0);
    $display("test packet check done");
    end_of_test;
  end
endmodule
